// ### hw/diag_ctrl_pkg.sv
// constants, codes and reset values shared by the diagnostic and maintenance control bank
// assumes one 25 MHz system clock; everything else is plain logic on that clock
package diag_ctrl_pkg;

	// ----------------------------------------------------------------
	// control channel byte layout
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_REG2      = 2'h1;  // ctrl_reg_select for diagnostic_gain_control
	localparam logic [1:0] SEL_REG3      = 2'h2;  // ctrl_reg_select for maintenance_tx_bits
	localparam int         DIAG_LSB      = 4;     // diag_select occupies bits 7:4
	localparam int         GAIN_BIT      = 3;     // converter_gain_sel
	localparam int         SWAP_BIT      = 2;     // role_swap
	localparam int         MAINT_LSB     = 2;     // maint_tx_bits occupy bits 7:2
	localparam logic [7:0] REG2_RESET    = 8'h01;
	localparam logic [7:0] REG3_RESET    = 8'hFE;

	// ----------------------------------------------------------------
	// diag_select codes
	// ----------------------------------------------------------------
	localparam logic [3:0] DIAG_NORMAL   = 4'h0;
	localparam logic [3:0] DIAG_BUSLOOP1 = 4'h1;  // 1..4: backplane_in looped to backplane_out
	localparam logic [3:0] DIAG_BUSLOOP4 = 4'h4;
	localparam logic [3:0] DIAG_RETLOOP1 = 4'h5;  // 5..8: backplane_out looped to backplane_in
	localparam logic [3:0] DIAG_RETLOOP4 = 4'h8;
	localparam logic [3:0] DIAG_TXLOOP   = 4'h9;  // line_transmit looped into the receiver
	localparam logic [3:0] DIAG_PULSE3   = 4'hA;
	localparam logic [3:0] DIAG_PULSE1   = 4'hB;
	localparam logic [3:0] DIAG_TONE     = 4'hC;
	localparam logic [3:0] DIAG_ILM      = 4'hD;  // insertion_loss_test
	localparam logic [3:0] DIAG_QUIET    = 4'hE;

	// ----------------------------------------------------------------
	// channels, data path and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] CH_B1         = 2'h0;
	localparam logic [1:0] CH_B2         = 2'h1;
	localparam logic [1:0] CH_D          = 2'h2;
	localparam int         FIFO_DEPTH    = 16;
	localparam int         FIFO_WIDTH    = 10;    // {channel, byte}
	localparam logic [7:0] ILM_PAYLOAD   = 8'hFF; // all ones, scrambled further down the line
	localparam int         CLK_PERIOD_NS = 40;
	localparam int         PULSE_TIME_NS = 1500000;
	localparam int         PULSE_CYCLES  = PULSE_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {TX_DATA, TX_QUIET, TX_PULSE, TX_TONE, TX_ILM} tx_mode_t;

	// looped channels for a loopback code, bit order {D, B2, B1}
	function automatic logic [2:0] loop_mask(input logic [3:0] code);
		logic [1:0] sub;
		sub = 2'(code - 4'h1);
		case (sub)
			2'h0:    loop_mask = 3'h1;
			2'h1:    loop_mask = 3'h2;
			2'h2:    loop_mask = 3'h3;
			default: loop_mask = 3'h7;
		endcase
	endfunction

endpackage

// ### hw/diag_mode_control_regs.sv
// diagnostic/gain and transmit maintenance control registers, loaded from the backplane control channel
// assumes the controller, activation logic and line transceiver run on clk_sys; only the role strap and nrst are pins
`timescale 1ns/10ps
`default_nettype none
//
// Function
// - in a bus-in to bus-out loopback the backplane input still goes to the line while activated.
// - both loopback directions work in single-port and dual-port backplane setups alike.
// - in a bus-out to bus-in loopback line receive data still reaches the backplane output.
// - in a bus-out to bus-in loopback the unlooped input channels still go to the line while activated.
// - the line-out to line-in loopback returns all transmitted channels internally and still drives the line.
// - the line-out to line-in loopback transmits whatever the activation state.
// - isolated-pulse codes send exactly one pulse every 1.5 ms and nothing else.
// - the insertion loss code sends framed all-ones payload through the scrambler.
// - role_swap selects the opposite role's polynomials and activation sequence in either role.
// - select 1,0 loads the third register, which feeds the maintenance channel.
// - maintenance bits pass transparently except CRC positions, which carry the generated CRC.
// - reset loads 0x01 into the second register and 0xFE into the third.
module diag_mode_control_regs
	import diag_ctrl_pkg::*;
#(
	parameter int PULSE_PERIOD = PULSE_CYCLES
) (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       ctrl_in_valid,
	input  wire logic [7:0] ctrl_in_byte,
	input  wire logic       line_termination_role,
	input  wire logic       activated,
	input  wire logic       frame_end,
	input  wire logic [5:0] crc_slot,
	input  wire logic [5:0] crc_bits,
	input  wire logic       backplane_in_valid,
	input  wire logic [7:0] backplane_in_data,
	input  wire logic [1:0] backplane_in_chan,
	output logic            backplane_in_ready,
	input  wire logic       line_rx_valid,
	input  wire logic [7:0] line_rx_data,
	input  wire logic [1:0] line_rx_chan,
	output logic            line_tx_valid,
	output logic      [7:0] line_tx_data,
	output logic      [1:0] line_tx_chan,
	input  wire logic       line_tx_ready,
	output logic            backplane_out_valid,
	output logic      [7:0] backplane_out_data,
	output logic      [1:0] backplane_out_chan,
	output var tx_mode_t    line_tx_mode,
	output logic            iso_pulse,
	output logic            iso_pulse_plus3,
	output logic            internal_loop,
	output logic            converter_gain_sel,
	output logic            use_nt_sequence,
	output logic      [3:0] diag_select,
	output logic      [5:0] maint_tx_bits,
	output logic            maint_tx_strobe
);
	typedef struct packed {
		logic [7:0]      reg2;
		logic [7:0]      reg3;
		logic [2:0]      role_sync;
		logic            role_lt;
		logic [15:0]     pulse_cnt;
		logic            pulse;
		logic            plus3;
		logic [5:0]      maint;
		logic            maint_stb;
		logic            tx_valid;
		logic [7:0]      tx_data;
		logic [1:0]      tx_chan;
		logic            bo_valid;
		logic [7:0]      bo_data;
		logic [1:0]      bo_chan;
		logic [2:0][7:0] rx_last;
		logic [1:0]      ilm_chan;
		logic            use_nt;
		logic            gain;
		tx_mode_t        mode;
		logic            int_loop;
	} ctrl_state_t;

	ctrl_state_t s_ff;
	ctrl_state_t nxt_s;
	logic [1:0]  rst_sync_ff;
	logic        rst_n_ff;
	logic        fifo_valid;
	logic [9:0]  fifo_word;
	logic        pop;
	logic [3:0]  diag;
	logic [2:0]  mask;
	logic        bus_loop;
	logic        ret_loop;
	logic        tx_loop;
	logic        pulse_mode;
	logic        ilm_mode;
	logic        send_ok;
	logic        out_free;
	logic [1:0]  fchan;
	logic [7:0]  fdata;

	// ----------------------------------------------------------------
	// reset release and data buffer
	// ----------------------------------------------------------------
	// release is synchronised so no flop sees a runt edge of nrst
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n_ff = rst_sync_ff[1];

	// backplane input waits here while the line is not taking data; full stalls the source
	word_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_in_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n_ff),
		.in_valid  (backplane_in_valid),
		.in_data   ({backplane_in_chan, backplane_in_data}),
		.in_ready  (backplane_in_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_word),
		.out_ready (pop)
	);

	// ----------------------------------------------------------------
	// mode decode from the stored diagnostic register
	// ----------------------------------------------------------------
	assign diag       = s_ff.reg2[DIAG_LSB +: 4];
	assign mask       = loop_mask(diag);
	assign bus_loop   = (diag >= DIAG_BUSLOOP1) && (diag <= DIAG_BUSLOOP4);
	assign ret_loop   = (diag >= DIAG_RETLOOP1) && (diag <= DIAG_RETLOOP4);
	assign tx_loop    = (diag == DIAG_TXLOOP);
	assign pulse_mode = (diag == DIAG_PULSE3) || (diag == DIAG_PULSE1);
	assign ilm_mode   = (diag == DIAG_ILM);
	assign fchan      = fifo_word[9:8];
	assign fdata      = fifo_word[7:0];
	// line data flows when activated, or always in the internal loop; test codes own the line
	assign send_ok    = (activated || tx_loop) && (diag <= DIAG_TXLOOP);
	assign out_free   = !s_ff.tx_valid || line_tx_ready;
	// a bus-in loop must reach backplane_out even while the line is idle
	assign pop        = fifo_valid && out_free && !ilm_mode && (send_ok || bus_loop);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_s           = s_ff;
		nxt_s.maint_stb = 1'b0;
		nxt_s.pulse     = 1'b0;
		nxt_s.bo_valid  = 1'b0;
		// role strap: third stage agrees with second before it counts
		nxt_s.role_sync = {s_ff.role_sync[1:0], line_termination_role};
		if (s_ff.role_sync[1] == s_ff.role_sync[2]) begin
			nxt_s.role_lt = s_ff.role_sync[2];
		end
		if (ctrl_in_valid) begin
			case (ctrl_in_byte[1:0])
				SEL_REG2: nxt_s.reg2 = ctrl_in_byte;
				SEL_REG3: nxt_s.reg3 = ctrl_in_byte;
				default: ;
			endcase
		end
		nxt_s.gain     = s_ff.reg2[GAIN_BIT];
		nxt_s.use_nt   = !s_ff.role_lt ^ s_ff.reg2[SWAP_BIT];
		nxt_s.int_loop = tx_loop;
		nxt_s.plus3    = (diag == DIAG_PULSE3);
		case (diag)
			DIAG_PULSE3, DIAG_PULSE1: nxt_s.mode = TX_PULSE;
			DIAG_TONE:                nxt_s.mode = TX_TONE;
			DIAG_ILM:                 nxt_s.mode = TX_ILM;
			DIAG_QUIET:               nxt_s.mode = TX_QUIET;
			4'hF:                     nxt_s.mode = TX_QUIET;   // reserved code kept silent
			default:                  nxt_s.mode = TX_DATA;
		endcase
		// one pulse per period, counter parked outside the pulse codes
		if (pulse_mode) begin
			if (s_ff.pulse_cnt == 16'(PULSE_PERIOD - 1)) begin
				nxt_s.pulse_cnt = 16'h0000;
				nxt_s.pulse     = 1'b1;
			end else begin
				nxt_s.pulse_cnt = 16'(s_ff.pulse_cnt + 1'b1);
			end
		end else begin
			nxt_s.pulse_cnt = 16'h0000;
		end
		// maintenance bits leave at each frame end, CRC slots replaced by local CRC
		if (frame_end) begin
			nxt_s.maint     = (s_ff.reg3[MAINT_LSB +: 6] & ~crc_slot) | (crc_bits & crc_slot);
			nxt_s.maint_stb = 1'b1;
		end
		// line receive: remember per channel for the return loop
		if (line_rx_valid && line_rx_chan != 2'h3) begin
			nxt_s.rx_last[line_rx_chan] = line_rx_data;
		end
		// line transmit
		if (out_free) begin
			nxt_s.tx_valid = 1'b0;
			if (ilm_mode) begin
				nxt_s.tx_valid = 1'b1;
				nxt_s.tx_data  = ILM_PAYLOAD;
				nxt_s.tx_chan  = s_ff.ilm_chan;
				nxt_s.ilm_chan = (s_ff.ilm_chan == CH_D) ? CH_B1 : 2'(s_ff.ilm_chan + 1'b1);
			end else if (pop && send_ok) begin
				nxt_s.tx_valid = 1'b1;
				nxt_s.tx_chan  = fchan;
				// looped channels carry what came back from the line; the rest pass through
				if (ret_loop && fchan != 2'h3 && mask[fchan]) begin
					nxt_s.tx_data = s_ff.rx_last[fchan];
				end else begin
					nxt_s.tx_data = fdata;
				end
			end
		end
		// backplane output: loop copies win; a colliding receive byte is dropped
		if (pop && (tx_loop || (bus_loop && fchan != 2'h3 && mask[fchan]))) begin
			nxt_s.bo_valid = 1'b1;
			nxt_s.bo_data  = fdata;
			nxt_s.bo_chan  = fchan;
		end else if (line_rx_valid && !tx_loop && !(bus_loop && line_rx_chan != 2'h3 && mask[line_rx_chan])) begin
			nxt_s.bo_valid = 1'b1;
			nxt_s.bo_data  = line_rx_data;
			nxt_s.bo_chan  = line_rx_chan;
		end
	end

	// control state register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_ff <= '{reg2: REG2_RESET, reg3: REG3_RESET, mode: TX_DATA, default: '0};
		end else if (!rst_n_ff) begin
			s_ff <= '{reg2: REG2_RESET, reg3: REG3_RESET, mode: TX_DATA, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flops
	// ----------------------------------------------------------------
	assign line_tx_valid       = s_ff.tx_valid;
	assign line_tx_data        = s_ff.tx_data;
	assign line_tx_chan        = s_ff.tx_chan;
	assign backplane_out_valid = s_ff.bo_valid;
	assign backplane_out_data  = s_ff.bo_data;
	assign backplane_out_chan  = s_ff.bo_chan;
	assign line_tx_mode        = s_ff.mode;
	assign iso_pulse           = s_ff.pulse;
	assign iso_pulse_plus3     = s_ff.plus3;
	assign internal_loop       = s_ff.int_loop;
	assign converter_gain_sel  = s_ff.gain;
	assign use_nt_sequence     = s_ff.use_nt;
	assign diag_select         = s_ff.reg2[DIAG_LSB +: 4];
	assign maint_tx_bits       = s_ff.maint;
	assign maint_tx_strobe     = s_ff.maint_stb;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n_ff);

	a_reset_values: assert property ($rose(rst_n_ff) |-> s_ff.reg2 == REG2_RESET && s_ff.reg3 == REG3_RESET)
		else $error("control registers not at reset values");
	a_reg2_load: assert property (ctrl_in_valid && ctrl_in_byte[1:0] == SEL_REG2 |=> diag_select == $past(ctrl_in_byte[7:4]))
		else $error("second register write not seen on diag_select");
	// non-crc positions carry the third register as stored at the frame end
	a_reg3_maint: assert property (frame_end |=>
		(maint_tx_bits & ~$past(crc_slot)) == ($past(s_ff.reg3[7:2]) & ~$past(crc_slot)))
		else $error("third register not sent as maintenance bits");
	a_crc_overwrite: assert property (frame_end |=> maint_tx_strobe && (maint_tx_bits & $past(crc_slot)) == ($past(crc_bits) & $past(crc_slot)))
		else $error("crc slot not overwritten");
	a_gain_follow: assert property (1'b1 |=> converter_gain_sel == $past(s_ff.reg2[GAIN_BIT]))
		else $error("converter gain not following register");
	a_quiet_silent: assert property (diag == DIAG_QUIET && !line_tx_valid && $stable(diag) |=> !line_tx_valid)
		else $error("line transmit in quiet mode");
	a_pulse_spacing: assert property (iso_pulse |-> $past(s_ff.pulse_cnt) == 16'(PULSE_PERIOD - 1) && $past(pulse_mode))
		else $error("isolated pulse off period");
	a_txloop_send: assert property (tx_loop && pop |=> line_tx_valid && backplane_out_valid && backplane_out_data == line_tx_data)
		else $error("internal loop not sending and returning");
	a_busloop_line: assert property (bus_loop && activated && pop |=> line_tx_valid && line_tx_data == $past(fdata))
		else $error("bus loop dropped line data");
	a_retloop_rx: assert property (ret_loop && line_rx_valid |=> backplane_out_valid && backplane_out_data == $past(line_rx_data))
		else $error("return loop blocked line receive");
	a_ilm_payload: assert property (ilm_mode && out_free |=> line_tx_valid && line_tx_data == ILM_PAYLOAD)
		else $error("insertion loss payload not all ones");

endmodule
`default_nettype wire

// ### hw/word_fifo.sv
// synchronous word FIFO with valid/ready on both sides
// assumes a synchronous active-low reset copy from the instantiating module
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [CW-1:0]               count;
		logic                        full;
		logic                        empty;
	} fifo_state_t;

	fifo_state_t s_ff;
	fifo_state_t nxt_s;
	logic        push;
	logic        pop;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// full and empty are registered so both ready and valid leave straight from flops
	always_comb begin
		nxt_s = s_ff;
		push  = in_valid && !s_ff.full;
		pop   = out_ready && !s_ff.empty;
		if (push) begin
			nxt_s.mem[s_ff.wp] = in_data;
			nxt_s.wp = (s_ff.wp == LAST) ? '0 : PW'(s_ff.wp + 1'b1);
		end
		if (pop) begin
			nxt_s.rp = (s_ff.rp == LAST) ? '0 : PW'(s_ff.rp + 1'b1);
		end
		if (push && !pop) begin
			nxt_s.count = CW'(s_ff.count + 1'b1);
		end else if (pop && !push) begin
			nxt_s.count = CW'(s_ff.count - 1'b1);
		end
		nxt_s.full  = (nxt_s.count == FULL);
		nxt_s.empty = (nxt_s.count == '0);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_ff <= '{empty: 1'b1, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign in_ready  = !s_ff.full;
	assign out_valid = !s_ff.empty;
	assign out_data  = s_ff.mem[s_ff.rp];

endmodule
`default_nettype wire

// ### test/backplane_ctrl_model.sv
// backplane controller model: control channel bytes and input channel words
// assumes the bench calls its tasks and that clk_sys is the bank's clock
`timescale 1ns/10ps
`default_nettype none
module backplane_ctrl_model (
	input  wire logic       clk_sys,
	output logic            ctrl_in_valid,
	output logic      [7:0] ctrl_in_byte,
	output logic            backplane_in_valid,
	output logic      [7:0] backplane_in_data,
	output logic      [1:0] backplane_in_chan,
	input  wire logic       backplane_in_ready
);
	logic [9:0] word_q[$];

	// idle levels; released lines show scrambled values, never the last one
	initial begin
		ctrl_in_valid = 1'b0;
		ctrl_in_byte = 8'hA5;
		backplane_in_valid = 1'b0;
		backplane_in_data = 8'h5A;
		backplane_in_chan = 2'h3;
	end

	// one byte per strobe; select bits in [1:0] pick the register
	task automatic send_ctrl(input logic [7:0] b);
		@(negedge clk_sys);
		ctrl_in_valid = 1'b1;
		ctrl_in_byte = b;
		@(negedge clk_sys);
		ctrl_in_valid = 1'b0;
		ctrl_in_byte = ~b;
	endtask

	// each word held until taken; a bounded wait keeps a refusal from hanging
	task automatic send_words(input int max_wait);
		logic [9:0] w;
		int         n;
		while (word_q.size() > 0) begin
			w = word_q.pop_front();
			@(negedge clk_sys);
			backplane_in_valid = 1'b1;
			{backplane_in_chan, backplane_in_data} = w;
			n = 0;
			// ready is a flop output: read it settled at the falling edge, the word goes at the next rising one
			while (backplane_in_ready !== 1'b1 && n < max_wait) begin
				@(negedge clk_sys);
				n++;
			end
			@(posedge clk_sys);
		end
		@(negedge clk_sys);
		backplane_in_valid = 1'b0;
		backplane_in_data = ~backplane_in_data;
		backplane_in_chan = ~backplane_in_chan;
	endtask
endmodule
`default_nettype wire

// ### test/diag_mode_control_regs_tb.sv
// self-checking bench for the diagnostic and maintenance control bank
// assumes backplane_ctrl_model as partner and a shortened pulse period
`timescale 1ns/10ps
`default_nettype none
module diag_mode_control_regs_tb
	import diag_ctrl_pkg::*;
;
	localparam int PP = 20;
	logic     clk_sys, nrst, line_termination_role, activated, frame_end, line_rx_valid, line_tx_ready;
	logic     ctrl_in_valid, backplane_in_valid, backplane_in_ready, line_tx_valid, backplane_out_valid;
	logic     iso_pulse, iso_pulse_plus3, internal_loop, converter_gain_sel, use_nt_sequence, maint_tx_strobe;
	logic     act_exp, ilm_on, stall_en;
	logic [1:0] line_rx_chan, backplane_in_chan, line_tx_chan, backplane_out_chan;
	logic [3:0] diag_select, cur_code;
	logic [5:0] crc_slot, crc_bits, maint_tx_bits;
	logic [7:0] line_rx_data, ctrl_in_byte, backplane_in_data, line_tx_data, backplane_out_data, last_rx[4];
	logic [9:0] line_q[$], bp_q[$];
	logic [31:0] seed, r;
	tx_mode_t line_tx_mode;
	int       err_total, n_compared, cycles, n;

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	backplane_ctrl_model model (.clk_sys(clk_sys), .ctrl_in_valid(ctrl_in_valid), .ctrl_in_byte(ctrl_in_byte),
		.backplane_in_valid(backplane_in_valid), .backplane_in_data(backplane_in_data),
		.backplane_in_chan(backplane_in_chan), .backplane_in_ready(backplane_in_ready));

	diag_mode_control_regs #(.PULSE_PERIOD(PP)) dut (.clk_sys(clk_sys), .nrst(nrst),
		.ctrl_in_valid(ctrl_in_valid), .ctrl_in_byte(ctrl_in_byte), .line_termination_role(line_termination_role),
		.activated(activated), .frame_end(frame_end), .crc_slot(crc_slot), .crc_bits(crc_bits),
		.backplane_in_valid(backplane_in_valid), .backplane_in_data(backplane_in_data),
		.backplane_in_chan(backplane_in_chan), .backplane_in_ready(backplane_in_ready),
		.line_rx_valid(line_rx_valid), .line_rx_data(line_rx_data), .line_rx_chan(line_rx_chan),
		.line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data), .line_tx_chan(line_tx_chan),
		.line_tx_ready(line_tx_ready), .backplane_out_valid(backplane_out_valid),
		.backplane_out_data(backplane_out_data), .backplane_out_chan(backplane_out_chan),
		.line_tx_mode(line_tx_mode), .iso_pulse(iso_pulse), .iso_pulse_plus3(iso_pulse_plus3),
		.internal_loop(internal_loop), .converter_gain_sel(converter_gain_sel),
		.use_nt_sequence(use_nt_sequence), .diag_select(diag_select), .maint_tx_bits(maint_tx_bits),
		.maint_tx_strobe(maint_tx_strobe));

	// ----------------------------------------------------------------
	// helpers and reference model
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic summarize();
		$display("mismatches %0d comparisons %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	function automatic tx_mode_t mode_of(input int c);
		if (c <= 9) return TX_DATA;
		if (c <= 11) return TX_PULSE;
		if (c == 12) return TX_TONE;
		if (c == 13) return TX_ILM;
		return TX_QUIET;
	endfunction

	function automatic logic looped(input logic [3:0] c, input logic [1:0] ch);
		logic [1:0] s;
		logic [2:0] m;
		s = 2'(c - 4'h1);
		m = (s == 2'h3) ? 3'h7 : (s == 2'h2) ? 3'h3 : (s == 2'h1) ? 3'h2 : 3'h1;
		return (ch != 2'h3) && m[ch];
	endfunction

	// where a popped word should appear, for the code in force when it drains
	task automatic exp_word(input logic [1:0] ch, input logic [7:0] d);
		if (cur_code == 4'h9) begin
			line_q.push_back({ch, d});
			bp_q.push_back({ch, d});
		end else if (cur_code >= 4'h1 && cur_code <= 4'h4) begin
			if (looped(cur_code, ch)) bp_q.push_back({ch, d});
			if (act_exp) line_q.push_back({ch, d});
		end else if (cur_code >= 4'h5 && cur_code <= 4'h8 && looped(cur_code, ch)) begin
			line_q.push_back({ch, last_rx[ch]});
		end else begin
			line_q.push_back({ch, d});
		end
	endtask

	task automatic frame(input logic [5:0] m);
		logic [5:0] s;
		logic [5:0] c;
		s = 6'(rnd());
		c = 6'(rnd());
		@(negedge clk_sys);
		frame_end = 1'b1;
		crc_slot = s;
		crc_bits = c;
		@(negedge clk_sys);
		frame_end = 1'b0;
		crc_slot = ~s;
		crc_bits = ~c;
		check("maint_bits", maint_tx_bits, (m & ~s) | (c & s));
		check("maint_strobe", maint_tx_strobe, 1);
		@(negedge clk_sys);
		check("strobe_end", maint_tx_strobe, 0);
	endtask

	// one traffic run; codes 5..8 first take a receive byte on every channel
	task automatic traffic(input logic [3:0] code, input logic act, input int nw);
		cur_code = code;
		act_exp = act;
		activated = act;
		model.send_ctrl({code, 4'h1});
		repeat (3) @(negedge clk_sys);
		for (int ch = 0; ch < 3 && code >= 4'h5 && code <= 4'h8; ch++) begin
			r = rnd();
			line_rx_valid = 1'b1;
			line_rx_chan = 2'(ch);
			line_rx_data = r[7:0];
			// every received byte still reaches the backplane, looped channel or not
			if (looped(code, 2'(ch))) last_rx[ch] = r[7:0];
			bp_q.push_back({2'(ch), r[7:0]});
			@(negedge clk_sys);
			line_rx_valid = 1'b0;
			line_rx_data = ~r[7:0];
			@(negedge clk_sys);
		end
		for (int i = 0; i < nw; i++) begin
			r = rnd();
			model.word_q.push_back({2'(i % 3), r[7:0]});
			exp_word(2'(i % 3), r[7:0]);
		end
		model.send_words(50);
		repeat (30) @(negedge clk_sys);
	endtask

	// ----------------------------------------------------------------
	// monitors, stalls and timeout
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			summarize();
		end
		if (nrst && line_tx_valid === 1'b1 && line_tx_ready === 1'b1) begin
			if (ilm_on) check("ilm_data", line_tx_data, 8'hFF);
			else check("line_word", {line_tx_chan, line_tx_data}, line_q.size() ? line_q.pop_front() : 10'h3FF);
		end
		if (nrst && backplane_out_valid === 1'b1)
			check("bp_word", {backplane_out_chan, backplane_out_data}, bp_q.size() ? bp_q.pop_front() : 10'h3FF);
	end

	// random back-pressure from the line side; a fresh draw each cycle so a stall never sticks
	always @(negedge clk_sys) begin
		if (stall_en) line_tx_ready = |(rnd() & 32'h00000018);
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{nrst, line_termination_role, activated, frame_end, line_rx_valid, stall_en, ilm_on, act_exp} = 8'h00;
		{crc_slot, crc_bits, line_rx_data, line_rx_chan, cur_code} = 28'h0;
		line_tx_ready = 1'b1;
		seed = 32'd45;
		{err_total, n_compared, cycles} = '0;
		repeat (2) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (8) @(negedge clk_sys);
		check("diag_rst", diag_select, 0);
		check("gain_rst", converter_gain_sel, 0);
		frame(6'h3F);
		r = rnd();
		line_termination_role = r[4];
		repeat (6) @(negedge clk_sys);
		// every code, with random gain and swap, then an ignored select
		for (int k = 0; k < 16; k++) begin
			r = rnd();
			ilm_on = ilm_on | (k == 13);
			model.send_ctrl({4'(k), r[1:0], 2'h1});
			repeat (3) @(negedge clk_sys);
			check("diag_sel", diag_select, k);
			check("tx_mode", line_tx_mode, mode_of(k));
			check("int_loop", internal_loop, k == 9);
			check("plus3", iso_pulse_plus3, k == 10);
			check("gain", converter_gain_sel, r[1]);
			check("nt_seq", use_nt_sequence, !line_termination_role ^ r[0]);
			if (k == 14) ilm_on = 1'b0;
			model.send_ctrl({~4'(k), r[1:0], k[0] ? 2'h3 : 2'h0});
			repeat (2) @(negedge clk_sys);
			check("ignored_sel", diag_select, k);
		end
		r = rnd();
		model.send_ctrl({r[7:2], 2'h2});
		repeat (2) @(negedge clk_sys);
		frame(r[7:2]);
		// pulse spacing for both pulse codes
		for (int c = 10; c < 12; c++) begin
			model.send_ctrl({4'(c), 4'h1});
			n = 0;
			while (iso_pulse !== 1'b1 && n < 3 * PP) begin
				@(negedge clk_sys);
				n++;
			end
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (iso_pulse !== 1'b1 && n < 3 * PP);
			check("pulse_gap", n, PP);
		end
		stall_en = 1'b1;
		traffic(4'h0, 1'b1, 6);
		traffic(4'h1, 1'b1, 6);
		traffic(4'h4, 1'b0, 6);
		traffic(4'h9, 1'b0, 6);
		traffic(4'h7, 1'b1, 6);
		// quiet mode holds the fifo until it refuses, then a drain with stalls
		model.send_ctrl(8'hE1);
		activated = 1'b0;
		cur_code = 4'h0;
		act_exp = 1'b1;
		for (int i = 0; i < 16; i++) begin
			r = rnd();
			model.word_q.push_back({2'(i % 3), r[7:0]});
			exp_word(2'(i % 3), r[7:0]);
		end
		model.send_words(50);
		repeat (3) @(negedge clk_sys);
		check("fifo_full", backplane_in_ready, 0);
		check("quiet_line", line_tx_valid, 0);
		activated = 1'b1;
		model.send_ctrl(8'h01);
		repeat (60) @(negedge clk_sys);
		check("fifo_free", backplane_in_ready, 1);
		check("line_left", line_q.size(), 0);
		check("bp_left", bp_q.size(), 0);
		summarize();
	end
endmodule
`default_nettype wire
